// [sram_write_ctrl.sv]
// host write controller for a 16-bit asynchronous static memory
module sram_write_ctrl (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // user write request
  input wire logic i_req,
  input wire logic [sram_wr_pkg::ADDR_W-1:0] i_addr,
  input wire logic [sram_wr_pkg::DATA_W-1:0] i_data,
  input wire logic [sram_wr_pkg::LANE_W-1:0] i_lane_en,
  input wire logic i_burst,
  // user status
  output logic o_ready,
  output logic o_done,
  // memory pins
  output logic [sram_wr_pkg::ADDR_W-1:0] o_addr,
  output logic [sram_wr_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  output logic o_chip_sel_n,
  output logic o_write_n,
  output logic o_out_en_n,
  output logic [sram_wr_pkg::LANE_W-1:0] o_lane_sel_n
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // registered pin levels and sequencer phase
  sram_wr_pkg::wr_state_type state_r, state_nxt;
  logic [sram_wr_pkg::CNT_W-1:0] cnt_r, cnt_nxt; // phase counter
  logic [sram_wr_pkg::ADDR_W-1:0] addr_r, addr_nxt; // address pins
  logic [sram_wr_pkg::DATA_W-1:0] data_r, data_nxt; // data pins
  logic doe_n_r, doe_n_nxt; // data drive enable, low drives
  logic cs_n_r, cs_n_nxt; // chip select
  logic we_n_r, we_n_nxt; // write strobe
  logic rdy_r, rdy_nxt; // ready for a request
  logic done_r, done_nxt; // write finished pulse
  logic burst_r, burst_nxt; // strobe kept low between writes
  logic [sram_wr_pkg::LANE_W-1:0] lane_r, lane_nxt; // lanes of the write
  logic out_en_n_r, out_en_n_nxt; // memory output enable, never low

  // carrier to the lane select driver
  sram_wr_if lanes ();

  // lane select driver
  sram_lane_drv u_lanes (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .lanes(lanes.drv)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // timing of one write with the strobe idle, edge by edge:
  //   take   chip select falls, address and data load
  //   +1     strobe falls and the data pins are driven
  //   +2     the requested lane selects fall; the write starts
  //   +3     lane selects rise and end the write; strobe and
  //          chip select rise with them unless a burst was asked
  //   +4     data pins released, done pulses, ready returns
  // with the strobe already low the lead phase is skipped, so a
  // burst write takes one cycle less.
  // hazards kept in mind:
  //   - the lane selects are always the last to fall and never
  //     rise after strobe or chip select, so the memory sees the write start and
  //     end on them, and address and data never move inside it
  //   - address and data change only at a take, which comes at
  //     least one cycle after the ending edge
  //   - output enable is never lowered, so the memory never
  //     drives the data pins while the controller does
  //   - a held strobe stays low in idle until a request without
  //     the burst flag completes; a user must end every burst
  //   - the lane enables are latched at the take, so the user
  //     may change them while the write runs
  //   - chip select stays low with a held strobe between writes
  // computes next pin levels and phase
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    doe_n_nxt = doe_n_r;
    cs_n_nxt = cs_n_r;
    we_n_nxt = we_n_r;
    rdy_nxt = rdy_r;
    done_nxt = 1'b0;
    burst_nxt = burst_r;
    lane_nxt = lane_r;
    // output enable held high: this host only writes
    out_en_n_nxt = 1'b1;
    // no load or release unless a phase asks for it
    lanes.load = 1'b0;
    lanes.release_lanes = 1'b0;
    // lanes come from the latched request, not the live input
    lanes.lane_en = lane_r;
    case (state_r)
      sram_wr_pkg::ST_IDLE: begin
        // take a request with at least one lane
        if (rdy_r && i_req && (i_lane_en != '0)) begin
          rdy_nxt = 1'b0;
          addr_nxt = i_addr;
          data_nxt = i_data;
          burst_nxt = i_burst;
          lane_nxt = i_lane_en; // latched for the lane phase
          cs_n_nxt = 1'b0;
          if (!we_n_r) begin
            // strobe already held low: lanes alone gate this write
            doe_n_nxt = 1'b0;
            state_nxt = sram_wr_pkg::ST_SETUP;
          end else begin
            cnt_nxt = sram_wr_pkg::CNT_W'(sram_wr_pkg::OE_HIGH_LEAD_CYC);
            state_nxt = sram_wr_pkg::ST_OE_LEAD;
          end
        end else if (!we_n_r && !burst_r) begin
          // burst over: lift the strobe
          we_n_nxt = 1'b1;
        end
      end
      sram_wr_pkg::ST_OE_LEAD: begin
        // output enable already high; wait before strobe falls
        if (cnt_r <= sram_wr_pkg::CNT_W'(1)) begin
          we_n_nxt = 1'b0; // memory floats its outputs now
          doe_n_nxt = 1'b0;
          state_nxt = sram_wr_pkg::ST_SETUP;
        end else begin
          // still counting the lead
          cnt_nxt = cnt_r - sram_wr_pkg::CNT_W'(1);
        end
      end
      sram_wr_pkg::ST_SETUP: begin
        // lanes go low last, so the write starts on them
        lanes.load = 1'b1;
        cnt_nxt = sram_wr_pkg::CNT_W'(sram_wr_pkg::STROBE_LOW_CYC);
        state_nxt = sram_wr_pkg::ST_STROBE;
      end
      sram_wr_pkg::ST_STROBE: begin
        // chip select, strobe and requested lanes low: memory writes
        if (cnt_r <= sram_wr_pkg::CNT_W'(1)) begin
          lanes.release_lanes = 1'b1; // lanes end the write
          if (!burst_r) begin
            // single write: strobe and chip select rise with lanes
            we_n_nxt = 1'b1;
            cs_n_nxt = 1'b1;
          end
          state_nxt = sram_wr_pkg::ST_HOLD;
        end else begin
          // keep the lanes low
          cnt_nxt = cnt_r - sram_wr_pkg::CNT_W'(1);
        end
      end
      sram_wr_pkg::ST_HOLD: begin
        // address and data kept one cycle past ending edge
        doe_n_nxt = 1'b1;
        done_nxt = 1'b1;
        rdy_nxt = 1'b1;
        state_nxt = sram_wr_pkg::ST_IDLE;
      end
      default: begin
        // unused codes fall back to idle
        state_nxt = sram_wr_pkg::ST_IDLE;
      end
    endcase
  end

  // register sequencer state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= sram_wr_pkg::ST_IDLE;
      cnt_r <= '0;
      addr_r <= '0;
      data_r <= '0;
      doe_n_r <= 1'b1;
      cs_n_r <= 1'b1;
      we_n_r <= 1'b1;
      rdy_r <= 1'b1;
      done_r <= 1'b0;
      burst_r <= 1'b0;
      lane_r <= '0;
      out_en_n_r <= 1'b1;
    end else begin
      // take the next values
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      doe_n_r <= doe_n_nxt;
      cs_n_r <= cs_n_nxt;
      we_n_r <= we_n_nxt;
      rdy_r <= rdy_nxt;
      done_r <= done_nxt;
      burst_r <= burst_nxt;
      lane_r <= lane_nxt;
      out_en_n_r <= out_en_n_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // limitations a user must know:
  //   - the strobe low time is counted in whole clock cycles,
  //     so a slower clock only lengthens the write
  //   - requests with no lane enabled are dropped without a sign
  //   - a request while ready is low is dropped as well
  // every pin comes straight from a register
  assign o_ready = rdy_r;
  assign o_done = done_r;
  assign o_addr = addr_r;
  assign o_data = data_r;
  assign o_data_oe_n = doe_n_r;
  assign o_chip_sel_n = cs_n_r;
  assign o_write_n = we_n_r;
  assign o_out_en_n = out_en_n_r; // write-only: stays high
  assign o_lane_sel_n = lanes.lane_sel_n;
endmodule

// [sram_wr_pkg.sv]
// constants shared by the static memory write controller
package sram_wr_pkg;
  // bus widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 2;
  // clock rate
  localparam int CLK_PERIOD_PS = 25000;
  // output enable high time before write strobe falls, in ps
  localparam int OE_HIGH_LEAD_PS = 4000;
  localparam int OE_HIGH_LEAD_CYC =
    (OE_HIGH_LEAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // write strobe low time, in ps
  localparam int STROBE_LOW_PS = 20000;
  localparam int STROBE_LOW_CYC =
    (STROBE_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // counter width
  localparam int CNT_W = 4;
  // inactive level of active-low strobes
  localparam logic [LANE_W-1:0] LANES_OFF = 2'h3;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_OE_LEAD, ST_SETUP, ST_STROBE, ST_HOLD
  } wr_state_type;
endpackage

// [sram_wr_if.sv]
// lane pin carrier between the sequencer and the lane driver
interface sram_wr_if;
  // byte lane selects, active low
  logic [sram_wr_pkg::LANE_W-1:0] lane_sel_n;
  // lanes enabled by the request
  logic [sram_wr_pkg::LANE_W-1:0] lane_en;
  // load pulse
  logic load;
  // release pulse
  logic release_lanes;
  modport seq (output lane_en, output load, output release_lanes,
               input lane_sel_n);
  modport drv (input lane_en, input load, input release_lanes,
               output lane_sel_n);
endinterface

// [sram_lane_drv.sv]
// byte lane select driver with registered outputs
module sram_lane_drv (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // carrier
  sram_wr_if.drv lanes
);
  // ---------------------------------------------------------------
  // lane select register
  // ---------------------------------------------------------------
  logic [sram_wr_pkg::LANE_W-1:0] sel_r;
  logic [sram_wr_pkg::LANE_W-1:0] sel_nxt;

  // next lane selects: only requested lanes go low
  always_comb begin
    sel_nxt = sel_r;
    if (lanes.release_lanes) begin
      sel_nxt = sram_wr_pkg::LANES_OFF;
    end else if (lanes.load) begin
      sel_nxt = ~lanes.lane_en;
    end
  end

  // register the selects
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sel_r <= sram_wr_pkg::LANES_OFF;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  assign lanes.lane_sel_n = sel_r;
endmodule

// [sram_wr_props.sv]
// checker for the write controller's memory pins
module sram_wr_props (
  input wire logic i_clock, i_rst, i_req, o_ready, o_done,
  input wire logic [17:0] i_addr, o_addr,
  input wire logic [15:0] i_data, o_data,
  input wire logic [1:0] i_lane_en, o_lane_sel_n,
  input wire logic o_data_oe_n, o_chip_sel_n, o_write_n, o_out_en_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // some lane select is active
  wire on = !(&o_lane_sel_n);
  // request accepted this edge
  wire take = i_req && o_ready && (|i_lane_en);
  property p_oe; o_out_en_n; endproperty
  a_oe: assert property (p_oe) else $error("oe low");
  property p_sel; on |-> !o_chip_sel_n && !o_write_n; endproperty
  a_sel: assert property (p_sel) else $error("lane alone");
  property p_drv; on |-> !o_data_oe_n; endproperty
  a_drv: assert property (p_drv) else $error("data undriven");
  property p_hold; on |=> $stable(o_addr) && $stable(o_data); endproperty
  a_hold: assert property (p_hold) else $error("pins moved");
  property p_done; $rose(&o_lane_sel_n) |=> o_done; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_lead;
    $fell(o_write_n) |-> !o_chip_sel_n && (&o_lane_sel_n) && $past(o_out_en_n);
  endproperty
  a_lead: assert property (p_lead) else $error("strobe order");
  property p_pulse;
    $fell(&o_lane_sel_n) |=> (&o_lane_sel_n);
  endproperty
  a_pulse: assert property (p_pulse) else $error("lane width");
  property p_take; take |=> !o_ready ##[1:8] o_done; endproperty
  a_take: assert property (p_take) else $error("write lost");
  c_done: cover property (o_done);
  c_burst: cover property (o_done && !o_write_n);
  c_refuse: cover property (i_req && o_ready && i_lane_en == 2'h0);
endmodule

// [sram_mem_model.sv]
// behavioural model of the static memory write path
module sram_mem_model (
  input wire logic [17:0] i_a,
  input wire logic [15:0] i_d,
  input wire logic i_cs_n, i_we_n, i_oe_n,
  input wire logic [1:0] i_lane_n,
  output logic o_drive
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [logic [17:0]];
  logic [1:0] lanes = 2'h0;
  // internal write while select, strobe and a lane are low
  wire act = !i_cs_n && !i_we_n && !(&i_lane_n);
  // lanes of the write in progress survive its ending edge
  always @(i_lane_n) if (!(&i_lane_n)) lanes = ~i_lane_n;
  // store on the edge that ends the write
  always @(negedge act) if (lanes != 2'h0) begin
    if (!mem.exists(i_a)) mem[i_a] = 16'h0;
    if (lanes[0]) mem[i_a][7:0] = i_d[7:0];
    if (lanes[1]) mem[i_a][15:8] = i_d[15:8];
  end
  // data pins float while the strobe is low
  assign o_drive = !i_cs_n && !i_oe_n && i_we_n;
endmodule

// [tb.sv]
// self-checking bench for the static memory write controller
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clock, i_rst, i_req, i_burst, o_ready, o_done, drive;
  logic [17:0] i_addr, o_addr;
  logic [15:0] i_data, o_data;
  logic [1:0] i_lane_en, o_lane_sel_n;
  logic o_data_oe_n, o_chip_sel_n, o_write_n, o_out_en_n;
  int err_count = 0;
  int cmp_count = 0;
  sram_write_ctrl dut (.*);
  sram_mem_model mem_i (.i_a(o_addr), .i_d(o_data), .i_cs_n(o_chip_sel_n),
    .i_we_n(o_write_n), .i_oe_n(o_out_en_n), .i_lane_n(o_lane_sel_n),
    .o_drive(drive));
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one write request, then wait for its done pulse
  task automatic wr(input logic [17:0] a, input logic [15:0] d,
    input logic [1:0] l, input logic b);
    int n;
    @(posedge i_clock);
    i_req <= 1'b1;
    i_addr <= a;
    i_data <= d;
    i_lane_en <= l;
    i_burst <= b;
    @(posedge i_clock);
    i_req <= 1'b0;
    i_lane_en <= 2'h0; // lanes must have been latched at the take
    for (n = 0; n < 12 && o_done !== 1'b1; n++) begin
      @(posedge i_clock);
      #1;
    end
    chk(o_done, 1'b1);
    chk(drive, 1'b0);
    chk(o_data_oe_n, 1'b1);
  endtask
  task automatic t_lanes;
    wr(18'h3_ffff, 16'ha5c3, 2'h3, 1'b0);
    chk(mem_i.mem[18'h3_ffff], 16'ha5c3);
    wr(18'h3_ffff, 16'h1234, 2'h1, 1'b0);
    chk(mem_i.mem[18'h3_ffff], 16'ha534);
    wr(18'h3_ffff, 16'h5678, 2'h2, 1'b0);
    chk(mem_i.mem[18'h3_ffff], 16'h5634);
    $display("lanes test done");
  endtask
  task automatic t_burst;
    wr(18'h0_0010, 16'h1111, 2'h3, 1'b1);
    chk(o_write_n, 1'b0);
    wr(18'h0_0011, 16'h2222, 2'h1, 1'b0);
    chk(mem_i.mem[18'h0_0010], 16'h1111);
    chk(mem_i.mem[18'h0_0011], 16'h0022);
    $display("burst test done");
  endtask
  task automatic t_refuse;
    @(posedge i_clock);
    i_req <= 1'b1;
    i_lane_en <= 2'h0;
    i_addr <= 18'h0_0020;
    repeat (3) @(posedge i_clock);
    i_req <= 1'b0;
    #1;
    chk({o_ready, o_chip_sel_n, o_lane_sel_n}, 4'hf);
    chk(mem_i.mem.exists(18'h0_0020), 0);
    $display("refuse test done");
  endtask
  initial begin
    i_rst = 1'b1;
    i_req = 1'b0;
    i_burst = 1'b0;
    i_addr = '0;
    i_data = '0;
    i_lane_en = '0;
    repeat (10) @(posedge i_clock);
    #1;
    chk({o_ready, o_done, o_chip_sel_n, o_write_n, o_lane_sel_n},
      6'h2f);
    @(posedge i_clock);
    i_rst <= 1'b0;
    $display("reset test done");
    t_lanes;
    t_burst;
    t_refuse;
    results;
  end
  // hang guard, far beyond the fewer than a hundred cycles the tests take
  initial begin
    #50000;
    err_count++;
    results;
  end
endmodule
bind sram_write_ctrl sram_wr_props chk_i (.*);
